/* bench/blc_core_tb.sv */
// Self-checking bench for the logic and bit operation core
`default_nettype none
module blc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import blc_pkg::*;

    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_valid = 1'b0;
    blc_cmd_type cmd = CMD_NONE;
    blc_logic_type logic_op = OP_AND;
    logic [7:0] operand = 8'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] bit_addr = 8'h00;
    logic bit_in = 1'b0;
    logic cmd_ready, done, carry_q, wr_en_q, bit_wr_q, bit_wr_val_q;
    logic bit_is_sfr, jump_q;
    logic [7:0] acc_q, wr_data_q;
    logic [1:0] ins_len_q;
    int n_fail = 0;
    int checks_done = 0;
    logic [7:0] m_acc = 8'h00;
    logic m_c = 1'b0;

    always #5 mclk = ~mclk;

    blc_core dut (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
        .logic_op(logic_op), .operand(operand), .mem_rdata(mem_rdata),
        .bit_addr(bit_addr), .bit_in(bit_in), .cmd_ready(cmd_ready),
        .done(done), .acc_q(acc_q), .carry_q(carry_q), .wr_data_q(wr_data_q),
        .wr_en_q(wr_en_q), .bit_wr_q(bit_wr_q), .bit_wr_val_q(bit_wr_val_q),
        .bit_is_sfr(bit_is_sfr), .jump_q(jump_q), .ins_len_q(ins_len_q));

    function automatic logic [7:0] f(blc_logic_type o, logic [7:0] a, b);
        case (o)
            OP_AND: return a & b;
            OP_OR: return a | b;
            default: return a ^ b;
        endcase
    endfunction

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One request; returns just after the edge that ends the done cycle
    task automatic issue(blc_cmd_type c, blc_logic_type o, logic [7:0] opd,
            logic [7:0] mem, logic bin, logic [1:0] n, logic [1:0] len);
        int k;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd <= c;
        logic_op <= o;
        operand <= opd;
        mem_rdata <= mem;
        bit_in <= bin;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        for (k = 1; k < 8; k++) begin
            #1;
            if (done === 1'b1)
                break;
            @(posedge mclk);
        end
        if (n != 2'h0) begin
            chk("cycles", 8'(k), {6'h0, n});
            chk("length", {6'h0, ins_len_q}, {6'h0, len});
        end
        @(posedge mclk);
        #1;
        chk("ready", {7'h0, cmd_ready}, 8'h01);
        chk("done_end", {7'h0, done}, 8'h00);
    endtask

    task automatic ld(logic [7:0] v);
        issue(CMD_CLEAR_ACC, OP_AND, 8'hff, 8'hff, 1'b0, 2'h1, 2'h1);
        issue(CMD_LOGIC_IMM, OP_OR, v, 8'h00, 1'b0, 2'h2, 2'h2);
        m_acc = v;
        chk("acc_load", acc_q, v);
    endtask

    task automatic t_logic();
        blc_logic_type o;
        for (int i = 0; i < 3; i++) begin
            o = blc_logic_type'(i);
            ld(8'hc6);
            issue(CMD_LOGIC_BANK, o, 8'h5a, 8'hff, 1'b0, 2'h1, 2'h1);
            m_acc = f(o, m_acc, 8'h5a);
            chk("acc_bank", acc_q, m_acc);
            issue(CMD_LOGIC_DIRECT, o, 8'hff, 8'h3c, 1'b0, 2'h2,
                2'h2);
            m_acc = f(o, m_acc, 8'h3c);
            chk("acc_direct", acc_q, m_acc);
            issue(CMD_LOGIC_POINTER, o, 8'h00, 8'hc3, 1'b0, 2'h2,
                2'h1);
            m_acc = f(o, m_acc, 8'hc3);
            chk("acc_pointer", acc_q, m_acc);
            issue(CMD_LOGIC_IMM, o, 8'h96, 8'hff, 1'b0, 2'h2, 2'h2);
            m_acc = f(o, m_acc, 8'h96);
            chk("acc_imm", acc_q, m_acc);
            issue(CMD_LOGIC_TO_DIRECT, o, 8'h0f, 8'h71, 1'b0, 2'h3,
                2'h2);
            chk("wr_en", {7'h0, wr_en_q}, 8'h01);
            chk("wr_data", wr_data_q, f(o, m_acc, 8'h71));
            chk("acc_kept", acc_q, m_acc);
            issue(CMD_IMM_TO_DIRECT, o, 8'h2b, 8'he4, 1'b0, 2'h3,
                2'h3);
            chk("wr_en", {7'h0, wr_en_q}, 8'h01);
            chk("wr_data", wr_data_q, f(o, 8'he4, 8'h2b));
        end
    endtask

    task automatic t_acc();
        blc_cmd_type ops [5] = '{CMD_ROTATE_LEFT, CMD_ROTATE_RIGHT, CMD_SWAP,
            CMD_INVERT_ACC, CMD_CLEAR_ACC};
        ld(8'h16);
        issue(CMD_BIT_MOVE_TO_CARRY, OP_AND, 8'h00, 8'h00, 1'b1, 2'h0, 2'h0);
        m_c = 1'b1;
        chk("carry", {7'h0, carry_q}, {7'h0, m_c});
        issue(CMD_ROTATE_LEFT_CARRY, OP_AND, 8'h00, 8'h00, 1'b0, 2'h1, 2'h1);
        {m_c, m_acc} = {m_acc, m_c};
        chk("acc_rlc", acc_q, m_acc);
        chk("carry_rlc", {7'h0, carry_q}, {7'h0, m_c});
        issue(CMD_ROTATE_RIGHT_CARRY, OP_AND, 8'h00, 8'h00, 1'b0, 2'h1, 2'h1);
        {m_acc, m_c} = {m_c, m_acc};
        chk("acc_rrc", acc_q, m_acc);
        chk("carry_rrc", {7'h0, carry_q}, {7'h0, m_c});
        for (int i = 0; i < 5; i++) begin
            issue(ops[i], OP_AND, 8'h00, 8'h00, 1'b0, 2'h1, 2'h1);
            case (ops[i])
                CMD_ROTATE_LEFT: m_acc = {m_acc[6:0], m_acc[7]};
                CMD_ROTATE_RIGHT: m_acc = {m_acc[0], m_acc[7:1]};
                CMD_SWAP: m_acc = {m_acc[3:0], m_acc[7:4]};
                CMD_INVERT_ACC: m_acc = ~m_acc;
                default: m_acc = 8'h00;
            endcase
            chk("acc_plain", acc_q, m_acc);
            chk("carry_kept", {7'h0, carry_q}, {7'h0, m_c});
        end
    endtask

    task automatic bitop(blc_cmd_type c, logic bin, logic wr, logic val,
            logic jmp);
        issue(c, OP_AND, 8'h00, 8'h00, bin, 2'h0, 2'h0);
        chk("bit_wr", {7'h0, bit_wr_q}, {7'h0, wr});
        if (wr)
            chk("bit_val", {7'h0, bit_wr_val_q}, {7'h0, val});
        chk("jump", {7'h0, jump_q}, {7'h0, jmp});
    endtask

    task automatic t_bit();
        logic [7:0] adr [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            bit_addr <= adr[i];
            #1;
            chk("bit_sfr", {7'h0, bit_is_sfr}, {7'h0, adr[i][7]});
        end
        bitop(CMD_BIT_SET, 1'b0, 1'b1, 1'b1, 1'b0);
        bitop(CMD_BIT_CLEAR, 1'b1, 1'b1, 1'b0, 1'b0);
        bitop(CMD_BIT_TOGGLE, 1'b1, 1'b1, 1'b0, 1'b0);
        bitop(CMD_BIT_TOGGLE, 1'b0, 1'b1, 1'b1, 1'b0);
        bitop(CMD_BIT_MOVE_FROM_CARRY, 1'b0, 1'b1, m_c, 1'b0);
        bitop(CMD_BIT_JUMP_SET, 1'b1, 1'b0, 1'b0, 1'b1);
        bitop(CMD_BIT_JUMP_SET, 1'b0, 1'b0, 1'b0, 1'b0);
        bitop(CMD_BIT_JUMP_CLEAR, 1'b1, 1'b0, 1'b0, 1'b0);
        bitop(CMD_BIT_JUMP_CLEAR, 1'b0, 1'b0, 1'b0, 1'b1);
        bitop(CMD_BIT_AND, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("carry_and", {7'h0, carry_q}, 8'h00);
        bitop(CMD_BIT_OR, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("carry_or", {7'h0, carry_q}, 8'h01);
    endtask

    task automatic t_xfer();
        issue(CMD_MOVE, OP_AND, 8'ha5, 8'h5a, 1'b0, 2'h0, 2'h0);
        chk("move_en", {7'h0, wr_en_q}, 8'h01);
        chk("move_data", wr_data_q, 8'ha5);
        issue(CMD_XDATA_READ, OP_AND, 8'hc1, 8'h3e, 1'b0, 2'h0, 2'h0);
        chk("xread", acc_q, 8'h3e);
        issue(CMD_XDATA_WRITE, OP_AND, 8'h11, 8'h00, 1'b0, 2'h0, 2'h0);
        chk("xwrite_en", {7'h0, wr_en_q}, 8'h01);
        chk("xwrite_data", wr_data_q, 8'h3e);
        issue(CMD_TABLE_READ, OP_AND, 8'h8e, 8'h71, 1'b0, 2'h0, 2'h0);
        chk("table", acc_q, 8'h71);
    endtask

    // Reset in mid-run, then a first request right after release
    task automatic t_reset();
        @(posedge mclk);
        nrst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("mid_rst_acc", acc_q, ACC_RST);
        chk("mid_rst_carry", {7'h0, carry_q}, 8'h00);
        chk("mid_rst_ready", {7'h0, cmd_ready}, 8'h01);
        @(posedge mclk);
        nrst <= 1'b1;
        m_c = 1'b0;
        ld(8'h3c);
        issue(CMD_SWAP, OP_AND, 8'h00, 8'h00, 1'b0, 2'h1, 2'h1);
        chk("swap_after_rst", acc_q, 8'hc3);
        chk("carry_after_rst", {7'h0, carry_q}, {7'h0, m_c});
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        chk("rst_ready", {7'h0, cmd_ready}, 8'h01);
        chk("rst_acc", acc_q, 8'h00);
        t_logic();
        t_acc();
        t_bit();
        t_xfer();
        t_reset();
        stop_test();
    end

    // Roughly twenty-five times the cycles that the scenarios need
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire

/* hw/blc_core.sv */
// Logic and bit operation datapath with cycle accounting
`default_nettype none
module blc_core
    import blc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire blc_pkg::blc_cmd_type cmd,
    input wire blc_pkg::blc_logic_type logic_op,
    input wire logic [7:0] operand,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] bit_addr,
    input wire logic bit_in,
    output logic cmd_ready,
    output logic done,
    output logic [7:0] acc_q,
    output logic carry_q,
    output logic [7:0] wr_data_q,
    output logic wr_en_q,
    output logic bit_wr_q,
    output logic bit_wr_val_q,
    output logic bit_is_sfr,
    output logic jump_q,
    output logic [1:0] ins_len_q
);
    import blc_pkg::*;

    blc_state_type state_q;
    blc_cmd_type cmd_q;
    blc_logic_type op_q;
    logic [7:0] opnd_q;
    logic [1:0] cyc_q;
    logic [1:0] need;
    logic [7:0] lu_a;
    logic [7:0] lu_b;
    logic [7:0] lu_y;

    function automatic logic [1:0] cyc_of(input blc_cmd_type c);
        unique case (c)
            CMD_LOGIC_DIRECT, CMD_LOGIC_POINTER,
            CMD_LOGIC_IMM: cyc_of = CYC_TWO; // [RL3] [RL4] [RL5]
            CMD_LOGIC_TO_DIRECT,
            CMD_IMM_TO_DIRECT: cyc_of = CYC_THREE; // [RL6] [RL7]
            default: cyc_of = CYC_ONE; // [RL2] [RL8] [RL9] [RL15]
        endcase
    endfunction

    function automatic logic [1:0] len_of(input blc_cmd_type c);
        unique case (c)
            CMD_LOGIC_DIRECT, CMD_LOGIC_IMM,
            CMD_LOGIC_TO_DIRECT: len_of = LEN_TWO; // [RL3] [RL5] [RL6]
            CMD_IMM_TO_DIRECT: len_of = LEN_THREE; // [RL7]
            default: len_of = LEN_ONE; // [RL2] [RL4] [RL8] [RL9] [RL15]
        endcase
    endfunction

    function automatic logic writes_mem(input blc_cmd_type c);
        writes_mem = (c == CMD_LOGIC_TO_DIRECT) ||
            (c == CMD_IMM_TO_DIRECT) || (c == CMD_MOVE) ||
            (c == CMD_XDATA_WRITE);
    endfunction

    assign need = cyc_of(cmd_q);
    assign cmd_ready = (state_q == ST_IDLE);
    // Bit space split: RAM bits below the count, special registers above
    assign bit_is_sfr = (bit_addr >= RAM_BITS); // [RL13]

    // Operand roles: accumulator into memory uses memory byte as target
    always_comb begin
        lu_a = acc_q;
        lu_b = opnd_q;
        if (cmd_q == CMD_IMM_TO_DIRECT) begin
            lu_a = mem_rdata; // [RL7]
        end else if (cmd_q == CMD_LOGIC_TO_DIRECT ||
                     cmd_q == CMD_LOGIC_DIRECT ||
                     cmd_q == CMD_LOGIC_POINTER) begin
            lu_b = mem_rdata; // [RL3] [RL4] [RL6]
        end
    end

    blc_logic_unit u_lu (
        .a(lu_a),
        .b(lu_b),
        .op(op_q),
        .y(lu_y)
    );

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cmd_q <= CMD_NONE;
            op_q <= OP_AND;
            opnd_q <= ACC_RST;
            cyc_q <= 2'h0;
            ins_len_q <= 2'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        cmd_q <= cmd;
                        op_q <= logic_op;
                        opnd_q <= operand;
                        ins_len_q <= len_of(cmd);
                        cyc_q <= CYC_ONE;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (cyc_q >= need) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cyc_q <= cyc_q + CYC_ONE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    logic last;
    assign last = (state_q == ST_EXEC) && (cyc_q >= need);
    assign done = last;

    // Accumulator update at the final cycle of each command
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= ACC_RST;
        end else if (last) begin
            unique case (cmd_q)
                CMD_LOGIC_BANK, CMD_LOGIC_DIRECT, CMD_LOGIC_POINTER,
                CMD_LOGIC_IMM: acc_q <= lu_y; // [RL2] [RL3] [RL4] [RL5]
                CMD_CLEAR_ACC: acc_q <= ACC_RST; // [RL15]
                CMD_INVERT_ACC: acc_q <= ~acc_q; // [RL15]
                CMD_ROTATE_LEFT: acc_q <= {acc_q[6:0], acc_q[7]}; // [RL15]
                CMD_ROTATE_RIGHT: acc_q <= {acc_q[0], acc_q[7:1]}; // [RL15]
                CMD_ROTATE_LEFT_CARRY:
                    acc_q <= {acc_q[6:0], carry_q}; // [RL8]
                CMD_ROTATE_RIGHT_CARRY:
                    acc_q <= {carry_q, acc_q[7:1]}; // [RL8]
                CMD_SWAP: acc_q <= {acc_q[3:0], acc_q[7:4]}; // [RL9]
                // Only the accumulator receives external or table data
                CMD_XDATA_READ, CMD_TABLE_READ:
                    acc_q <= mem_rdata; // [RL11] [RL12]
                default: acc_q <= acc_q;
            endcase
        end
    end

    // Carry as ninth bit and single-bit operations on it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            carry_q <= 1'b0;
        end else if (last) begin
            unique case (cmd_q)
                CMD_ROTATE_LEFT_CARRY: carry_q <= acc_q[7]; // [RL8]
                CMD_ROTATE_RIGHT_CARRY: carry_q <= acc_q[0]; // [RL8]
                CMD_BIT_MOVE_TO_CARRY: carry_q <= bit_in; // [RL14]
                CMD_BIT_OR: carry_q <= carry_q | bit_in; // [RL14]
                CMD_BIT_AND: carry_q <= carry_q & bit_in; // [RL14]
                default: carry_q <= carry_q; // [RL15]
            endcase
        end
    end

    // Byte writes back to memory
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_en_q <= 1'b0;
            wr_data_q <= ACC_RST;
        end else begin
            wr_en_q <= last && writes_mem(cmd_q);
            if (last) begin
                unique case (cmd_q)
                    CMD_LOGIC_TO_DIRECT,
                    CMD_IMM_TO_DIRECT: wr_data_q <= lu_y; // [RL6] [RL7]
                    CMD_MOVE: wr_data_q <= opnd_q; // [RL10]
                    CMD_XDATA_WRITE: wr_data_q <= acc_q; // [RL11]
                    default: wr_data_q <= wr_data_q;
                endcase
            end
        end
    end

    // Bit writes and bit-conditional jumps
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bit_wr_q <= 1'b0;
            bit_wr_val_q <= 1'b0;
            jump_q <= 1'b0;
        end else begin
            bit_wr_q <= last && (cmd_q == CMD_BIT_SET ||
                cmd_q == CMD_BIT_CLEAR || cmd_q == CMD_BIT_TOGGLE ||
                cmd_q == CMD_BIT_MOVE_FROM_CARRY); // [RL14]
            jump_q <= last && ((cmd_q == CMD_BIT_JUMP_SET && bit_in) ||
                (cmd_q == CMD_BIT_JUMP_CLEAR && !bit_in)); // [RL14]
            if (last) begin
                unique case (cmd_q)
                    CMD_BIT_SET: bit_wr_val_q <= 1'b1; // [RL14]
                    CMD_BIT_CLEAR: bit_wr_val_q <= 1'b0; // [RL14]
                    CMD_BIT_TOGGLE: bit_wr_val_q <= ~bit_in; // [RL14]
                    CMD_BIT_MOVE_FROM_CARRY:
                        bit_wr_val_q <= carry_q; // [RL14]
                    default: bit_wr_val_q <= bit_wr_val_q;
                endcase
            end
        end
    end

    // Cycle counts measured from acceptance to completion
    property p_three_cyc;
        @(posedge mclk) disable iff (!nrst)
        (cmd_ready && cmd_valid && (cmd == CMD_IMM_TO_DIRECT ||
            cmd == CMD_LOGIC_TO_DIRECT)) |-> !done ##1 !done ##1 !done
            ##1 done;
    endproperty
    a_three_cyc: assert property (p_three_cyc) // [RL6]
        else $error("three cycle command timing wrong");

    property p_two_cyc;
        @(posedge mclk) disable iff (!nrst)
        (cmd_ready && cmd_valid && (cmd == CMD_LOGIC_IMM ||
            cmd == CMD_LOGIC_DIRECT || cmd == CMD_LOGIC_POINTER))
            |-> ##1 !done ##1 done;
    endproperty
    a_two_cyc: assert property (p_two_cyc) // [RL5]
        else $error("two cycle command timing wrong");

    property p_one_cyc;
        @(posedge mclk) disable iff (!nrst)
        (cmd_ready && cmd_valid && cmd == CMD_LOGIC_BANK) |-> ##1 done;
    endproperty
    a_one_cyc: assert property (p_one_cyc) // [RL2]
        else $error("one cycle command timing wrong");

    property p_swap;
        @(posedge mclk) disable iff (!nrst)
        (done && cmd_q == CMD_SWAP) |=>
            acc_q == {$past(acc_q[3:0]), $past(acc_q[7:4])};
    endproperty
    a_swap: assert property (p_swap) // [RL9]
        else $error("nibble swap result wrong");

    property p_rlc;
        @(posedge mclk) disable iff (!nrst)
        (done && cmd_q == CMD_ROTATE_LEFT_CARRY) |=>
            {carry_q, acc_q} == {$past(acc_q), $past(carry_q)};
    endproperty
    a_rlc: assert property (p_rlc) // [RL8]
        else $error("rotate through carry wrong");

    property p_keep_carry;
        @(posedge mclk) disable iff (!nrst)
        (done && (cmd_q == CMD_ROTATE_LEFT || cmd_q == CMD_ROTATE_RIGHT ||
            cmd_q == CMD_INVERT_ACC || cmd_q == CMD_CLEAR_ACC))
            |=> $stable(carry_q);
    endproperty
    a_keep_carry: assert property (p_keep_carry) // [RL15]
        else $error("carry changed by plain accumulator op");

    property p_xor;
        @(posedge mclk) disable iff (!nrst)
        (done && cmd_q == CMD_LOGIC_BANK && op_q == OP_XOR) |=>
            acc_q == ($past(acc_q) ^ $past(opnd_q));
    endproperty
    a_xor: assert property (p_xor) // [RL1]
        else $error("bitwise xor result wrong");

    property p_mem_wr;
        @(posedge mclk) disable iff (!nrst)
        (done && cmd_q == CMD_IMM_TO_DIRECT) |=> wr_en_q &&
            wr_data_q == (($past(op_q) == OP_AND) ?
            ($past(mem_rdata) & $past(opnd_q)) :
            ($past(op_q) == OP_OR) ?
            ($past(mem_rdata) | $past(opnd_q)) :
            ($past(mem_rdata) ^ $past(opnd_q)));
    endproperty
    a_mem_wr: assert property (p_mem_wr) // [RL7]
        else $error("direct byte write back wrong");

    property p_bit_set;
        @(posedge mclk) disable iff (!nrst)
        (done && cmd_q == CMD_BIT_SET) |=> bit_wr_q && bit_wr_val_q;
    endproperty
    a_bit_set: assert property (p_bit_set) // [RL14]
        else $error("bit set not written");

    property p_rrc;
        @(posedge mclk) disable iff (!nrst)
        (done && cmd_q == CMD_ROTATE_RIGHT_CARRY) |=>
            {acc_q, carry_q} == {$past(carry_q), $past(acc_q)};
    endproperty
    a_rrc: assert property (p_rrc) // [RL8]
        else $error("rotate right through carry wrong");

    property p_ptr_and;
        @(posedge mclk) disable iff (!nrst)
        (done && cmd_q == CMD_LOGIC_POINTER && op_q == OP_AND) |=>
            acc_q == ($past(acc_q) & $past(mem_rdata));
    endproperty
    a_ptr_and: assert property (p_ptr_and) // [RL4]
        else $error("pointer and result wrong");

    property p_acc_kept;
        @(posedge mclk) disable iff (!nrst)
        (done && cmd_q == CMD_LOGIC_TO_DIRECT) |=>
            $stable(acc_q) && wr_en_q;
    endproperty
    a_acc_kept: assert property (p_acc_kept) // [RL6]
        else $error("accumulator changed by write to direct byte");
endmodule
`default_nettype wire

/* hw/blc_logic_unit.sv */
// Bitwise logic unit for byte operands
`default_nettype none
module blc_logic_unit
    import blc_pkg::*;
(
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire blc_pkg::blc_logic_type op,
    output logic [7:0] y
);
    import blc_pkg::*;

    // One bit pair per call, so no bit can see its neighbours
    function automatic logic bit_op(input blc_logic_type o, input logic x,
            input logic z);
        unique case (o)
            OP_AND: bit_op = x & z; // [RL1]
            OP_OR: bit_op = x | z; // [RL1]
            OP_XOR: bit_op = x ^ z; // [RL1]
            default: bit_op = 1'b0;
        endcase
    endfunction

    genvar i;
    generate
        for (i = 0; i < DW; i++) begin : g_bit
            assign y[i] = bit_op(op, a[i], b[i]); // [RL1]
        end
    endgenerate
endmodule
`default_nettype wire

/* hw/blc_pkg.sv */
// Constants and types for the byte logic and bit operation core
// Functional notes
// RL1: Bitwise logic combines only matching bit positions.
// RL2: Bank register logic: one byte, one cycle.
// RL3: Direct byte to accumulator: two bytes, two cycles.
// RL4: Pointer RAM to accumulator: one byte, two cycles.
// RL5: Immediate to accumulator: two bytes, two cycles.
// RL6: Accumulator into direct byte: two bytes, three cycles.
// RL7: Immediate into direct byte: three bytes, three cycles.
// RL8: Carry rotations are nine-bit, one byte, one cycle.
// RL9: Nibble swap is one byte, one cycle.
// RL10: Core moves use any RAM or special register.
// RL11: External RAM moves only accumulator, pointer addressed.
// RL12: Table lookups read program memory, base plus index.
// RL13: 128 bit-addressable RAM bits plus bit registers.
// RL14: Bit move, set, clear, toggle, OR, AND, jumps.
// RL15: Clear, invert, plain rotations keep carry, one cycle.
`default_nettype none
package blc_pkg;
    localparam int unsigned DW = 8;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] RAM_BITS = 8'h80;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    typedef enum logic [1:0] {
        OP_AND = 2'h0, OP_OR = 2'h1, OP_XOR = 2'h2
    } blc_logic_type;

    typedef enum logic [4:0] {
        CMD_NONE = 5'h00,
        CMD_LOGIC_BANK = 5'h01,
        CMD_LOGIC_DIRECT = 5'h02,
        CMD_LOGIC_POINTER = 5'h03,
        CMD_LOGIC_IMM = 5'h04,
        CMD_LOGIC_TO_DIRECT = 5'h05,
        CMD_IMM_TO_DIRECT = 5'h06,
        CMD_CLEAR_ACC = 5'h07,
        CMD_INVERT_ACC = 5'h08,
        CMD_ROTATE_LEFT = 5'h09,
        CMD_ROTATE_LEFT_CARRY = 5'h0a,
        CMD_ROTATE_RIGHT = 5'h0b,
        CMD_ROTATE_RIGHT_CARRY = 5'h0c,
        CMD_SWAP = 5'h0d,
        CMD_MOVE = 5'h0e,
        CMD_XDATA_READ = 5'h0f,
        CMD_XDATA_WRITE = 5'h10,
        CMD_TABLE_READ = 5'h11,
        CMD_BIT_MOVE_TO_CARRY = 5'h12,
        CMD_BIT_MOVE_FROM_CARRY = 5'h13,
        CMD_BIT_SET = 5'h14,
        CMD_BIT_CLEAR = 5'h15,
        CMD_BIT_TOGGLE = 5'h16,
        CMD_BIT_OR = 5'h17,
        CMD_BIT_AND = 5'h18,
        CMD_BIT_JUMP_SET = 5'h19,
        CMD_BIT_JUMP_CLEAR = 5'h1a
    } blc_cmd_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_WRITE = 4'b1000
    } blc_state_type;
endpackage
`default_nettype wire
